// ==== hw/asm_defines.vh ====
// Purpose: constants for the drive process-data image assembly block
// Assumes: four-byte images, byte 0 first, words low byte first
// Notes: image numbers are the identifiers seen by the network master
// How it works
// [RQ1] Image layouts are fixed; nothing about them is configurable at run time.
// [RQ2] Default image identifiers sit in the vendor-specific identifier range.
// [RQ3] Each image's data is readable and writable as byte-array attribute 3; writes to produced images 70, 71 and 101 are answered read only.
// [RQ4] Explicit writes to a consuming image bound to an I/O connection are refused.
// [RQ5] Class attribute reports highest supported image identifier as 101, read only.
// [RQ6] Image 20: byte0 bit0 forward run, bit2 fault reset; byte1 unused.
// [RQ7] Image 21: bits 0,1,2,5,6 fwd, rev, fault reset, net control, net reference.
// [RQ8] Speed output images carry speed reference in bytes 2 and 3, low first.
// [RQ9] Image 100 carries control word bytes 0-1, reference speed bytes 2-3.
// [RQ10] Image 70: byte0 bit0 faulted, bit2 running forward; byte1 unused.
// [RQ11] Image 71 byte0 bits 0..7: fault, warn, fwd, rev, ready, ctrl, ref, at-ref.
// [RQ12] Image 71 byte 1 holds the drive control state machine state.
// [RQ13] Speed input images carry actual speed in bytes 2 and 3, low first.
// [RQ14] Image 101 carries status word bytes 0-1, output speed bytes 2-3.
// [RQ15] Consumed bits drive control and drive attributes per fixed mapping.
// [RQ16] Produced flags come from control and drive attributes per fixed mapping.
// [RQ17] Consume via image 21 by default; new selection applies after restart only.
// [RQ18] Produce via image 71 by default; new selection applies after restart only.
// [RQ19] Unassigned produced bits read zero; unassigned consumed bits are ignored.
`ifndef ASM_DEFINES_VH
`define ASM_DEFINES_VH

// ----------------------------------------
// Image identifiers
// ----------------------------------------
`define IMG_OUT_BASIC 8'h14
`define IMG_OUT_EXT 8'h15
`define IMG_OUT_TRANSP 8'h64
`define IMG_IN_BASIC 8'h46
`define IMG_IN_EXT 8'h47
`define IMG_IN_TRANSP 8'h65
`define IMG_MAX_ID 8'h65

// ----------------------------------------
// Attributes
// ----------------------------------------
`define ATTR_DATA 8'h03
`define CLASS_ATTR_REV 8'h01
`define CLASS_ATTR_MAX 8'h02
`define CLASS_REV_VALUE 16'h0002

// ----------------------------------------
// Byte 0 bit positions
// ----------------------------------------
`define B_FWD 0
`define B_REV 1
`define B_FRST 2
`define B_NCTL 5
`define B_NREF 6
`define S_FLT 0
`define S_WARN 1
`define S_FWD 2
`define S_REV 3
`define S_RDY 4
`define S_CTL 5
`define S_REF 6
`define S_ATR 7

// ----------------------------------------
// Answer codes on the explicit port
// ----------------------------------------
`define ANS_OK 2'h0
`define ANS_BUSY 2'h1
`define ANS_BAD 2'h2
`define ANS_RO 2'h3

`endif

// ==== hw/image_select.v ====
// Purpose: holds the active image selection, latched only at restart
// Assumes: stored selection is steady while rst_n is low
// Notes: a pending value can be read back but does not act until restart
`timescale 1ns/1ps
`include "asm_defines.vh"

module image_select (
  input wire clk,
  input wire rst_n,
  input wire [7:0] stored_sel,
  input wire [7:0] default_sel,
  input wire [7:0] alt_sel_a,
  input wire [7:0] alt_sel_b,
  output reg [7:0] active_ff
);

  reg loaded_ff;

  // ----------------------------------------
  // Capture after reset release
  // ----------------------------------------
  // Async reset takes a constant; stored value is sampled on first clock
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loaded_ff <= 1'b0;
      active_ff <= 8'h00;
    end else if (!loaded_ff) begin
      loaded_ff <= 1'b1;
      // RQ17 RQ18 restart only
      if (stored_sel == alt_sel_a || stored_sel == alt_sel_b ||
          stored_sel == default_sel) begin
        active_ff <= stored_sel;
      end else begin
        active_ff <= default_sel; // Unknown value falls back to default
      end
    end
  end

endmodule

// ==== hw/drive_process_data_assembly.v ====
// Purpose: packs produced and unpacks consumed four-byte process-data images
// Assumes: cyclic and explicit requests are single-cycle strobes on clk
// Notes: image layouts are hard wired; only the active pair is on the cyclic path
`timescale 1ns/1ps
`include "asm_defines.vh"

module drive_process_data_assembly (
  input wire clk,
  input wire rst_n,
  input wire [7:0] cons_sel_stored,
  input wire [7:0] prod_sel_stored,
  output wire [7:0] cons_sel_active,
  output wire [7:0] prod_sel_active,
  input wire io_conn_open,
  input wire cyc_rx_valid,
  input wire [31:0] cyc_rx_data,
  input wire cyc_tx_req,
  output reg cyc_tx_valid_ff,
  output reg [31:0] cyc_tx_data_ff,
  input wire exp_req,
  input wire exp_write,
  input wire exp_class,
  input wire [7:0] exp_instance,
  input wire [7:0] exp_attr,
  input wire [31:0] exp_wdata,
  output reg exp_done_ff,
  output reg [1:0] exp_status_ff,
  output reg [31:0] exp_rdata_ff,
  output reg cmd_run_fwd_ff,
  output reg cmd_run_rev_ff,
  output reg cmd_fault_reset_ff,
  output reg network_control_select_ff,
  output reg network_reference_select_ff,
  output reg [15:0] speed_reference_ff,
  output reg [15:0] profile_control_word_ff,
  output reg [15:0] profile_reference_speed_ff,
  input wire faulted,
  input wire warning,
  input wire running_forward_flag,
  input wire running_reverse_flag,
  input wire ready,
  input wire control_from_net,
  input wire reference_from_net,
  input wire at_reference,
  input wire [7:0] drive_state,
  input wire [15:0] speed_actual,
  input wire [15:0] profile_status_word,
  input wire [15:0] profile_output_speed
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Word to bytes 0..1 low first
  function [15:0] swap_le;
    input [15:0] w;
    begin
      swap_le = {w[7:0], w[15:8]};
    end
  endfunction

  // Produced image by identifier; unassigned bits read zero
  function [31:0] pack_in;
    input [7:0] id;
    input [7:0] flags;
    input [7:0] st;
    input [15:0] spd;
    input [15:0] sw;
    input [15:0] osp;
    begin
      pack_in = 32'h0000_0000;
      // RQ10 basic input
      if (id == `IMG_IN_BASIC) begin
        pack_in[24 + `S_FLT] = flags[`S_FLT]; // Byte 0 sits at bits 31:24, bit 0 at 24
        pack_in[24 + `S_FWD] = flags[`S_FWD];
        pack_in[15:0] = swap_le(spd);
      // RQ11 RQ12 extended input
      end else if (id == `IMG_IN_EXT) begin
        pack_in = {8'h00, st, swap_le(spd)};
        pack_in[31:24] = flags; // Flag vector is already in bit order 7..0
      // RQ14 transparent input
      end else if (id == `IMG_IN_TRANSP) begin
        pack_in = {swap_le(sw), swap_le(osp)};
      end
    end
  endfunction

  // Bit n of byte 0 in a packed word (byte 0 at top, bit 0 at bit 24)
  function b0;
    input [31:0] img;
    input [2:0] n;
    begin
      b0 = img[24 + n];
    end
  endfunction

  // ----------------------------------------
  // Restart-latched selections
  // ----------------------------------------
  image_select u_cons_sel (
    .clk(clk),
    .rst_n(rst_n),
    .stored_sel(cons_sel_stored),
    .default_sel(`IMG_OUT_EXT),
    .alt_sel_a(`IMG_OUT_BASIC),
    .alt_sel_b(`IMG_OUT_TRANSP),
    .active_ff(cons_sel_active)
  );

  image_select u_prod_sel (
    .clk(clk),
    .rst_n(rst_n),
    .stored_sel(prod_sel_stored),
    .default_sel(`IMG_IN_EXT),
    .alt_sel_a(`IMG_IN_BASIC),
    .alt_sel_b(`IMG_IN_TRANSP),
    .active_ff(prod_sel_active)
  );

  // ----------------------------------------
  // Consumed image stores
  // ----------------------------------------
  reg [31:0] out_img_ff [0:2];
  reg [31:0] nxt_out_img [0:2];
  wire [7:0] flags;
  wire [31:0] in_img;
  integer i;

  // RQ16 status mapping
  assign flags = {at_reference, reference_from_net, control_from_net, ready,
                  running_reverse_flag, running_forward_flag, warning, faulted};

  // Index of a consuming image, 3 when not one
  function [1:0] out_idx;
    input [7:0] id;
    begin
      if (id == `IMG_OUT_BASIC) begin
        out_idx = 2'd0;
      end else if (id == `IMG_OUT_EXT) begin
        out_idx = 2'd1;
      end else if (id == `IMG_OUT_TRANSP) begin
        out_idx = 2'd2;
      end else begin
        out_idx = 2'd3;
      end
    end
  endfunction

  wire [1:0] rx_idx = out_idx(cons_sel_active);
  wire [1:0] ex_idx = out_idx(exp_instance);
  wire ex_is_out = (ex_idx != 2'd3);
  wire ex_is_in = (exp_instance == `IMG_IN_BASIC) || (exp_instance == `IMG_IN_EXT) ||
                  (exp_instance == `IMG_IN_TRANSP);
  // RQ4 bound image busy
  wire ex_bound = io_conn_open && (exp_instance == cons_sel_active);
  wire ex_write_ok = exp_req && exp_write && !exp_class && ex_is_out && !ex_bound &&
                     (exp_attr == `ATTR_DATA);

  // Image writes; the explicit write is applied after the cyclic one, so it wins when both target one image
  always @* begin
    for (i = 0; i < 3; i = i + 1) begin
      nxt_out_img[i] = out_img_ff[i];
    end
    if (cyc_rx_valid && rx_idx != 2'd3) begin
      nxt_out_img[rx_idx] = cyc_rx_data;
    end
    // RQ3 data attribute write
    if (ex_write_ok) begin
      nxt_out_img[ex_idx] = exp_wdata;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < 3; i = i + 1) begin
        out_img_ff[i] <= 32'h0000_0000;
      end
    end else begin
      for (i = 0; i < 3; i = i + 1) begin
        out_img_ff[i] <= nxt_out_img[i];
      end
    end
  end

  // ----------------------------------------
  // Command decode from active consuming image
  // ----------------------------------------
  wire [31:0] act_img = (rx_idx == 2'd3) ? 32'h0000_0000 : nxt_out_img[rx_idx];

  // RQ1 fixed layouts
  // RQ6 RQ7 RQ8 RQ9 RQ15 RQ19 unpack and map
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_run_fwd_ff <= 1'b0;
      cmd_run_rev_ff <= 1'b0;
      cmd_fault_reset_ff <= 1'b0;
      network_control_select_ff <= 1'b0;
      network_reference_select_ff <= 1'b0;
      speed_reference_ff <= 16'h0000;
      profile_control_word_ff <= 16'h0000;
      profile_reference_speed_ff <= 16'h0000;
    end else begin
      cmd_run_fwd_ff <= (rx_idx != 2'd2) && b0(act_img, `B_FWD);
      cmd_run_rev_ff <= (rx_idx == 2'd1) && b0(act_img, `B_REV);
      cmd_fault_reset_ff <= (rx_idx != 2'd2) && b0(act_img, `B_FRST);
      network_control_select_ff <= (rx_idx == 2'd1) && b0(act_img, `B_NCTL);
      network_reference_select_ff <= (rx_idx == 2'd1) && b0(act_img, `B_NREF);
      speed_reference_ff <= (rx_idx == 2'd2) ? 16'h0000 : swap_le(act_img[15:0]);
      profile_control_word_ff <= (rx_idx == 2'd2) ? swap_le(act_img[31:16]) : 16'h0000;
      profile_reference_speed_ff <= (rx_idx == 2'd2) ? swap_le(act_img[15:0]) : 16'h0000;
    end
  end

  // ----------------------------------------
  // Cyclic produce
  // ----------------------------------------
  // RQ13 RQ18 active produced image
  assign in_img = pack_in(prod_sel_active, flags, drive_state, speed_actual,
                          profile_status_word, profile_output_speed);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_tx_valid_ff <= 1'b0;
      cyc_tx_data_ff <= 32'h0000_0000;
    end else begin
      cyc_tx_valid_ff <= cyc_tx_req;
      if (cyc_tx_req) begin
        cyc_tx_data_ff <= in_img;
      end
    end
  end

  // ----------------------------------------
  // Explicit access answers
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      exp_done_ff <= 1'b0;
      exp_status_ff <= `ANS_OK;
      exp_rdata_ff <= 32'h0000_0000;
    end else begin
      exp_done_ff <= exp_req;
      if (exp_req) begin
        exp_rdata_ff <= 32'h0000_0000;
        exp_status_ff <= `ANS_OK;
        if (exp_class) begin
          // RQ5 max instance
          if (exp_write) begin
            exp_status_ff <= `ANS_RO;
          end else if (exp_attr == `CLASS_ATTR_MAX) begin
            exp_rdata_ff <= {24'h000000, `IMG_MAX_ID};
          end else if (exp_attr == `CLASS_ATTR_REV) begin
            exp_rdata_ff <= {16'h0000, `CLASS_REV_VALUE};
          end else begin
            exp_status_ff <= `ANS_BAD;
          end
        end else if (exp_attr != `ATTR_DATA || !(ex_is_out || ex_is_in)) begin
          exp_status_ff <= `ANS_BAD;
        end else if (exp_write) begin
          // RQ4 refuse bound write
          if (ex_is_in) begin
            exp_status_ff <= `ANS_RO;
          end else if (ex_bound) begin
            exp_status_ff <= `ANS_BUSY;
          end
        end else if (ex_is_out) begin
          exp_rdata_ff <= out_img_ff[ex_idx];
        end else begin
          // RQ2 RQ3 produced data read
          exp_rdata_ff <= pack_in(exp_instance, flags, drive_state, speed_actual,
                                  profile_status_word, profile_output_speed);
        end
      end
    end
  end

endmodule

// ==== verification/image_monitor.sv ====
// Purpose: concurrent checks on the image assembly block ports
// Assumes: one clock domain, async active-low reset
// Notes: bound from the bench top file
`timescale 1ns/1ps
`include "asm_defines.vh"
module image_monitor (
  input wire clk,
  input wire rst_n,
  input wire [7:0] cons_sel_active,
  input wire [7:0] prod_sel_active,
  input wire io_conn_open,
  input wire cyc_rx_valid,
  input wire [31:0] cyc_rx_data,
  input wire cyc_tx_req,
  input wire cyc_tx_valid_ff,
  input wire [31:0] cyc_tx_data_ff,
  input wire exp_req,
  input wire exp_write,
  input wire exp_class,
  input wire [7:0] exp_instance,
  input wire [7:0] exp_attr,
  input wire exp_done_ff,
  input wire [1:0] exp_status_ff,
  input wire [31:0] exp_rdata_ff,
  input wire cmd_run_fwd_ff,
  input wire cmd_run_rev_ff,
  input wire cmd_fault_reset_ff,
  input wire [15:0] speed_reference_ff,
  input wire [7:0] drive_state,
  input wire [15:0] speed_actual
);
  reg [31:0] rx_prev_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Copy of cyc_rx_data from the previous clock, valid or not, so slices can be compared a cycle later
  always @(posedge clk) begin
    rx_prev_ff <= cyc_rx_data;
  end
  // -------------------------------
  // Request sequences
  // -------------------------------
  sequence s_bound_write;
    exp_req && exp_write && !exp_class && exp_attr == `ATTR_DATA
      && exp_instance == cons_sel_active && io_conn_open;
  endsequence
  sequence s_ext_rx;
    cyc_rx_valid && !exp_req && cons_sel_active == `IMG_OUT_EXT;
  endsequence
  sequence s_ext_tx;
    cyc_tx_req && prod_sel_active == `IMG_IN_EXT;
  endsequence
  a_tx_answer: assert property (cyc_tx_req |=> cyc_tx_valid_ff)
    else $error("produced image not answered");
  a_tx_quiet: assert property (!cyc_tx_req |=> !cyc_tx_valid_ff)
    else $error("produced valid without request");
  a_exp_answer: assert property (exp_req |=> exp_done_ff ##1 !exp_done_ff || exp_req)
    else $error("explicit request not answered once");
  a_bound_refused: assert property (s_bound_write |=> exp_status_ff == `ANS_BUSY)
    else $error("write to bound image not refused");
  a_max_instance: assert property (exp_req && !exp_write && exp_class
    && exp_attr == `CLASS_ATTR_MAX |=> exp_status_ff == `ANS_OK && exp_rdata_ff == 32'h00000065)
    else $error("max instance read wrong");
  a_ext_speed_out: assert property (s_ext_tx
    |=> {cyc_tx_data_ff[7:0], cyc_tx_data_ff[15:8]} == $past(speed_actual))
    else $error("actual speed bytes wrong");
  a_ext_state_out: assert property (s_ext_tx |=> cyc_tx_data_ff[23:16] == $past(drive_state))
    else $error("drive state byte wrong");
  a_ext_speed_in: assert property (s_ext_rx
    |=> {speed_reference_ff[7:0], speed_reference_ff[15:8]} == rx_prev_ff[15:0])
    else $error("speed reference unpacked wrong");
  a_ext_cmd_in: assert property (s_ext_rx
    |=> {cmd_fault_reset_ff, cmd_run_rev_ff, cmd_run_fwd_ff} == rx_prev_ff[26:24])
    else $error("command bits unpacked wrong");
  a_sel_held: assert property (cons_sel_active != 8'h00
    |=> $stable(cons_sel_active) && $stable(prod_sel_active))
    else $error("image selection changed without restart");
endmodule

// ==== verification/net_master.sv ====
// Purpose: network master model that sends and collects cyclic images
// Assumes: requests launched just after a rising edge
// Notes: idle data is inverted so stale bytes never look fresh
`timescale 1ns/1ps
module net_master (
  input wire clk,
  input wire cyc_tx_valid_ff,
  input wire [31:0] cyc_tx_data_ff,
  output reg cyc_rx_valid,
  output reg [31:0] cyc_rx_data,
  output reg cyc_tx_req
);
  initial begin
    cyc_rx_valid = 1'b0;
    cyc_rx_data = 32'h0;
    cyc_tx_req = 1'b0;
  end
  // Whole image in one strobe, byte 0 on top
  task send(input [31:0] img);
    begin
      @(posedge clk);
      cyc_rx_valid <= 1'b1;
      cyc_rx_data <= img;
      @(posedge clk);
      cyc_rx_valid <= 1'b0;
      cyc_rx_data <= ~img;
      @(posedge clk);
      #1;
    end
  endtask
  // Produced image is taken in the cycle its valid stands
  task fetch(output [31:0] img, output ok);
    begin
      @(posedge clk);
      cyc_tx_req <= 1'b1;
      @(posedge clk);
      cyc_tx_req <= 1'b0;
      #1;
      img = cyc_tx_data_ff;
      ok = cyc_tx_valid_ff;
    end
  endtask
endmodule

// ==== verification/tb.sv ====
// Purpose: directed regression of the image assembly block
// Assumes: selections act only after a reset pulse
// Notes: expected images are built by hand from the layouts
`timescale 1ns/1ps
`include "asm_defines.vh"
`define CHK(nm, e, g) begin compares = compares + 1; if ((g) !== (e)) begin \
  bad_count = bad_count + 1; $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb;
  reg clk, rst_n, io_conn_open, exp_req, exp_write, exp_class, ok;
  reg [7:0] cons_st, prod_st, exp_instance, exp_attr, st_flags, drive_state;
  reg [15:0] speed_actual, status_word, out_speed;
  reg [31:0] exp_wdata, img;
  wire [7:0] cons_sel_active, prod_sel_active;
  wire cyc_rx_valid, cyc_tx_req, cyc_tx_valid_ff, exp_done_ff;
  wire run_fwd, run_rev, flt_rst, net_ctl, net_ref;
  wire [31:0] cyc_rx_data, cyc_tx_data_ff, exp_rdata_ff;
  wire [1:0] exp_status_ff;
  wire [15:0] speed_ref, ctl_word, ref_speed;
  wire [4:0] cmd_vec = {run_fwd, run_rev, flt_rst, net_ctl, net_ref};
  integer bad_count = 0;
  integer compares = 0;
  drive_process_data_assembly u_dut (.clk(clk), .rst_n(rst_n), .cons_sel_stored(cons_st),
    .prod_sel_stored(prod_st), .cons_sel_active(cons_sel_active),
    .prod_sel_active(prod_sel_active), .io_conn_open(io_conn_open),
    .cyc_rx_valid(cyc_rx_valid), .cyc_rx_data(cyc_rx_data), .cyc_tx_req(cyc_tx_req),
    .cyc_tx_valid_ff(cyc_tx_valid_ff), .cyc_tx_data_ff(cyc_tx_data_ff), .exp_req(exp_req),
    .exp_write(exp_write), .exp_class(exp_class), .exp_instance(exp_instance),
    .exp_attr(exp_attr), .exp_wdata(exp_wdata), .exp_done_ff(exp_done_ff),
    .exp_status_ff(exp_status_ff), .exp_rdata_ff(exp_rdata_ff), .cmd_run_fwd_ff(run_fwd),
    .cmd_run_rev_ff(run_rev), .cmd_fault_reset_ff(flt_rst),
    .network_control_select_ff(net_ctl), .network_reference_select_ff(net_ref),
    .speed_reference_ff(speed_ref), .profile_control_word_ff(ctl_word),
    .profile_reference_speed_ff(ref_speed), .faulted(st_flags[0]), .warning(st_flags[1]),
    .running_forward_flag(st_flags[2]), .running_reverse_flag(st_flags[3]),
    .ready(st_flags[4]), .control_from_net(st_flags[5]), .reference_from_net(st_flags[6]),
    .at_reference(st_flags[7]), .drive_state(drive_state), .speed_actual(speed_actual),
    .profile_status_word(status_word), .profile_output_speed(out_speed));
  net_master u_master (.clk(clk), .cyc_tx_valid_ff(cyc_tx_valid_ff),
    .cyc_tx_data_ff(cyc_tx_data_ff), .cyc_rx_valid(cyc_rx_valid),
    .cyc_rx_data(cyc_rx_data), .cyc_tx_req(cyc_tx_req));
  // -------------------------------
  // Clock, tasks and verdict
  // -------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Stored selection must be steady while reset is low
  task restart(input [7:0] c, input [7:0] p);
    begin
      @(posedge clk);
      rst_n <= 1'b0;
      cons_st <= c;
      prod_st <= p;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
    end
  endtask
  task explicit(input w, input c, input [7:0] i, input [7:0] a, input [31:0] wd);
    begin
      @(posedge clk);
      exp_req <= 1'b1;
      exp_write <= w;
      exp_class <= c;
      exp_instance <= i;
      exp_attr <= a;
      exp_wdata <= wd;
      @(posedge clk);
      exp_req <= 1'b0;
      #1;
      `CHK("done", 1'b1, exp_done_ff)
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    #100000;
    bad_count = bad_count + 1;
    summarize;
  end
  initial begin
    {rst_n, io_conn_open, exp_req, exp_write, exp_class} = 5'h00;
    {cons_st, prod_st, exp_instance, exp_attr, st_flags, drive_state} = 48'h0;
    {speed_actual, status_word, out_speed, exp_wdata} = 80'h0;
    restart(8'h00, 8'h00);
    `CHK("cons_sel", 8'h15, cons_sel_active)
    `CHK("prod_sel", 8'h47, prod_sel_active)
    u_master.send(32'hE7FF3412);
    `CHK("cmd21", 5'h1F, cmd_vec)
    `CHK("speed21", 16'h1234, speed_ref)
    `CHK("ctl_word21", 16'h0000, ctl_word)
    @(posedge clk);
    st_flags <= 8'hA5;
    drive_state <= 8'h03;
    speed_actual <= 16'hBEEF;
    u_master.fetch(img, ok);
    `CHK("img71", 32'hA503EFBE, img)
    `CHK("valid71", 1'b1, ok)
    $display("test extended images done");
    io_conn_open <= 1'b1;
    explicit(0, 1, 8'h00, `CLASS_ATTR_MAX, 32'h0);
    `CHK("max_inst", 32'h00000065, exp_rdata_ff)
    explicit(1, 1, 8'h00, `CLASS_ATTR_MAX, 32'h5);
    `CHK("max_ro", `ANS_RO, exp_status_ff)
    explicit(1, 0, 8'h15, `ATTR_DATA, 32'h01000000);
    `CHK("bound", `ANS_BUSY, exp_status_ff)
    `CHK("bound_speed", 16'h1234, speed_ref)
    explicit(1, 0, 8'h15, 8'h04, 32'h0);
    `CHK("bad_attr", `ANS_BAD, exp_status_ff)
    explicit(0, 0, 8'h30, `ATTR_DATA, 32'h0);
    `CHK("bad_inst", `ANS_BAD, exp_status_ff)
    io_conn_open <= 1'b0;
    explicit(1, 0, 8'h15, `ATTR_DATA, 32'h02005600);
    `CHK("wr_ok", `ANS_OK, exp_status_ff)
    `CHK("wr_cmd", 5'h08, cmd_vec)
    `CHK("wr_speed", 16'h0056, speed_ref)
    explicit(0, 0, 8'h15, `ATTR_DATA, 32'h0);
    `CHK("rd21", 32'h02005600, exp_rdata_ff)
    explicit(1, 0, 8'h47, `ATTR_DATA, 32'h0);
    `CHK("wr71", `ANS_RO, exp_status_ff)
    $display("test explicit access done");
    cons_st <= 8'h14;
    prod_st <= 8'h46;
    repeat (3) @(posedge clk);
    `CHK("no_restart", 8'h15, cons_sel_active)
    restart(8'h14, 8'h46);
    `CHK("cons20", 8'h14, cons_sel_active)
    `CHK("prod70", 8'h46, prod_sel_active)
    u_master.send(32'hFFFF5678);
    `CHK("cmd20", 5'h14, cmd_vec)
    `CHK("speed20", 16'h7856, speed_ref)
    st_flags <= 8'hFF;
    u_master.fetch(img, ok);
    `CHK("img70", 32'h0500EFBE, img)
    $display("test basic images done");
    restart(8'h64, 8'h65);
    u_master.send(32'h34127856);
    `CHK("ctl_word", 16'h1234, ctl_word)
    `CHK("ref_speed", 16'h5678, ref_speed)
    `CHK("cmd100", 5'h00, cmd_vec)
    status_word <= 16'hCAFE;
    out_speed <= 16'h0102;
    u_master.fetch(img, ok);
    `CHK("img101", 32'hFECA0201, img)
    $display("test transparent images done");
    summarize;
  end
endmodule
bind drive_process_data_assembly image_monitor u_monitor (.clk(clk), .rst_n(rst_n),
  .cons_sel_active(cons_sel_active), .prod_sel_active(prod_sel_active),
  .io_conn_open(io_conn_open), .cyc_rx_valid(cyc_rx_valid), .cyc_rx_data(cyc_rx_data),
  .cyc_tx_req(cyc_tx_req), .cyc_tx_valid_ff(cyc_tx_valid_ff),
  .cyc_tx_data_ff(cyc_tx_data_ff), .exp_req(exp_req), .exp_write(exp_write),
  .exp_class(exp_class), .exp_instance(exp_instance), .exp_attr(exp_attr),
  .exp_done_ff(exp_done_ff), .exp_status_ff(exp_status_ff), .exp_rdata_ff(exp_rdata_ff),
  .cmd_run_fwd_ff(cmd_run_fwd_ff), .cmd_run_rev_ff(cmd_run_rev_ff),
  .cmd_fault_reset_ff(cmd_fault_reset_ff), .speed_reference_ff(speed_reference_ff),
  .drive_state(drive_state), .speed_actual(speed_actual));
